/* inc/can_filt_pkg.sv */
/*
 Constants for the receive acceptance filter block: register indices, field positions,
 reset values and mask selector codes. Assumes a 32-bit Avalon-MM slave with byte addresses.
*/
package can_filt_pkg;
   localparam int NUM_FILTERS = 16;
   localparam int NUM_MASKS = 3;
   localparam int ADDR_W = 8;
   localparam int IDX_LSB = 2;
   // Word indices; the byte address is four times the index.
   localparam logic [5:0] IDX_FLT_SID = 6'h00;
   localparam logic [5:0] IDX_FLT_EID = 6'h10;
   localparam logic [5:0] IDX_MSK_SID = 6'h20;
   localparam logic [5:0] IDX_MSK_EID = 6'h23;
   localparam logic [5:0] IDX_SEL_LO = 6'h26;
   localparam logic [5:0] IDX_SEL_HI = 6'h27;
   localparam logic [5:0] IDX_BUF_PTR = 6'h28;
   localparam logic [5:0] IDX_END = 6'h2c;
   // Standard identifier register layout, shared by filters and masks.
   localparam int SID_LSB = 5;
   localparam int SID_W = 11;
   localparam int TYPE_BIT = 3;
   localparam int EID_W = 18;
   localparam logic [15:0] SID_REG_MASK = 16'hffeb;
   localparam logic [15:0] SEL_RESET = 16'h0000;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [1:0] MSK_SET0 = 2'h0;
   localparam logic [1:0] MSK_SET1 = 2'h1;
   localparam logic [1:0] MSK_SET2 = 2'h2;
   localparam logic [1:0] MSK_RESERVED = 2'h3;
   localparam logic [3:0] PTR_FIFO = 4'hf;
endpackage

/* inc/can_filt_if.sv */
/*
 Carrier between the register top and the filter comparator: configuration, the frame
 under test and the match result. Assumes both ends share sys_clk.
*/
`timescale 1ns/1ps
interface can_filt_if;
   logic clk;
   logic rst;
   logic frame_ext;
   logic [10:0] frame_sid;
   logic [17:0] frame_eid;
   logic [15:0][15:0] flt_sid;
   logic [15:0][15:0] flt_eid;
   logic [2:0][15:0] msk_sid;
   logic [2:0][15:0] msk_eid;
   logic [31:0] msk_sel;
   logic [63:0] buf_ptr;
   logic [15:0] hit;
   logic hit_any;
   logic [3:0] hit_index;
   logic [3:0] hit_ptr;
   modport cfg (output clk, rst, frame_ext, frame_sid, frame_eid, flt_sid, flt_eid, msk_sid, msk_eid,
                msk_sel, buf_ptr, input hit, hit_any, hit_index, hit_ptr);
   modport match (input clk, rst, frame_ext, frame_sid, frame_eid, flt_sid, flt_eid, msk_sid, msk_eid,
                  msk_sel, buf_ptr, output hit, hit_any, hit_index, hit_ptr);
endinterface

/* hdl/can_filt_match.sv */
/*
 Combinational comparator of one frame identifier against sixteen filters.
 Assumes the configuration is stable while a frame is presented.
*/
`timescale 1ns/1ps
module can_filt_match (
   // Carrier
   can_filt_if.match m
);
   function automatic logic [17:0] ext_bits(input logic [15:0] sid_reg, input logic [15:0] eid_reg);
      ext_bits = {sid_reg[1:0], eid_reg};
   endfunction

   always_comb begin
      logic [1:0] sel;
      logic [15:0] msid;
      logic [15:0] fsid;
      logic sid_ok;
      logic eid_ok;
      logic type_ok;
      sel = can_filt_pkg::MSK_SET0;
      msid = '0;
      fsid = '0;
      sid_ok = 1'b0;
      eid_ok = 1'b0;
      type_ok = 1'b0;
      m.hit = '0;
      for (int i = 0; i < can_filt_pkg::NUM_FILTERS; i++) begin
         sel = m.msk_sel[2*i +: 2];
         fsid = m.flt_sid[i];
         msid = (sel == can_filt_pkg::MSK_RESERVED) ? '0 : m.msk_sid[sel];
         // A cleared mask bit is a don't-care, a set bit must compare equal.
         sid_ok = ((m.frame_sid ^ fsid[can_filt_pkg::SID_LSB +: can_filt_pkg::SID_W])
                   & msid[can_filt_pkg::SID_LSB +: can_filt_pkg::SID_W]) == '0;
         // Standard frames carry no extended bits, so only extended frames compare them.
         eid_ok = !m.frame_ext || (((m.frame_eid ^ ext_bits(fsid, m.flt_eid[i]))
                   & ((sel == can_filt_pkg::MSK_RESERVED) ? 18'h00000
                   : ext_bits(msid, m.msk_eid[sel]))) == '0);
         type_ok = !msid[can_filt_pkg::TYPE_BIT] || (m.frame_ext == fsid[can_filt_pkg::TYPE_BIT]);
         // The reserved selector never matches, so a bad setting cannot route frames.
         m.hit[i] = (sel != can_filt_pkg::MSK_RESERVED) && sid_ok && eid_ok && type_ok;
      end
   end

   // Lowest-numbered hitting filter decides where the frame goes.
   always_comb begin
      m.hit_any = |m.hit;
      m.hit_index = '0;
      for (int i = can_filt_pkg::NUM_FILTERS - 1; i >= 0; i--) begin
         if (m.hit[i]) begin
            m.hit_index = 4'(i);
         end
      end
      m.hit_ptr = m.buf_ptr[4*m.hit_index +: 4];
   end

   chk_type_gate: assert property (@(posedge m.clk) disable iff (m.rst)
      (m.msk_sel[1:0] == 2'h0 && m.msk_sid[0][3] && m.frame_ext != m.flt_sid[0][3]) |-> !m.hit[0])
      else $error("filter 0 hit a frame of the wrong identifier type");
   chk_sid_compare: assert property (@(posedge m.clk) disable iff (m.rst)
      (m.hit[0] && m.msk_sel[1:0] == 2'h1) |->
      ((m.frame_sid ^ m.flt_sid[0][15:5]) & m.msk_sid[1][15:5]) == 11'h000)
      else $error("filter 0 hit with an unmasked standard bit different");
   chk_eid_compare: assert property (@(posedge m.clk) disable iff (m.rst)
      (m.hit[0] && m.frame_ext && m.msk_sel[1:0] == 2'h2) |->
      ((m.frame_eid[15:0] ^ m.flt_eid[0]) & m.msk_eid[2]) == 16'h0000)
      else $error("filter 0 hit with an unmasked extended bit different");
   chk_dont_care: assert property (@(posedge m.clk) disable iff (m.rst)
      (m.msk_sel[3:2] == 2'h0 && m.msk_sid[0] == 16'h0000 && m.msk_eid[0] == 16'h0000) |-> m.hit[1])
      else $error("filter 1 missed with an all-clear mask");
   chk_reserved_sel: assert property (@(posedge m.clk) disable iff (m.rst)
      (m.msk_sel[1:0] == 2'h3) |-> !m.hit[0])
      else $error("filter 0 hit under the reserved selector");
endmodule // can_filt_match

/* hdl/can_filt_top.sv */
/*
 Receive acceptance filter with sixteen filters, three masks, per-filter mask selectors and
 buffer pointers, behind an Avalon-MM slave. Assumes frame identifiers come from receive
 logic on sys_clk_i with a one-cycle valid strobe.
*/
// Functional notes
// - Each filter keeps 18 extended identifier bits, 2 of them in its standard register; unmasked bits must equal the frame.
// - Selector 00, 01, 10 picks mask set 0, 1 or 2 for that filter.
// - Filters 0 to 7 selectors sit in the low selection register, two bits each.
// - Filters 8 to 15 selectors sit in the high selection register, two bits each.
// - A set mask bit compares the identifier bit, a clear bit ignores it.
// - Each filter keeps 11 standard identifier bits; unmasked bits must equal the frame.
// - With the mask type bit set, frame type must equal the filter extended-enable bit.
// - An accepted frame goes to the buffer its filter points to; 1111 means FIFO.
`timescale 1ns/1ps
module can_filt_top (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic srst_i,
   // Avalon-MM slave
   input wire logic [can_filt_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Frame identifier from the receiver
   input wire logic frame_valid_i,
   input wire logic frame_ext_i,
   input wire logic [10:0] frame_sid_i,
   input wire logic [17:0] frame_eid_i,
   // Acceptance result
   output logic accept_valid_o,
   output logic [3:0] accept_filter_o,
   output logic [3:0] accept_buffer_o,
   output logic accept_fifo_o
);
   typedef struct packed {
      logic [15:0][15:0] flt_sid;
      logic [15:0][15:0] flt_eid;
      logic [2:0][15:0] msk_sid;
      logic [2:0][15:0] msk_eid;
      logic [15:0] sel_lo;
      logic [15:0] sel_hi;
      logic [3:0][15:0] buf_ptr;
      logic [15:0] rdata;
      logic rd_done;
      logic acc_valid;
      logic [3:0] acc_filter;
      logic [3:0] acc_ptr;
   } state_s;

   state_s st;
   state_s next_st;
   can_filt_if fi ();
   logic [5:0] idx;

   function automatic logic in_range(input logic [5:0] a, input logic [5:0] lo, input logic [5:0] hi);
      in_range = (a >= lo) && (a < hi);
   endfunction

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be,
                                         input logic [15:0] keep);
      logic [15:0] n;
      n = old;
      if (be[0]) begin
         n[7:0] = wd[7:0];
      end
      if (be[1]) begin
         n[15:8] = wd[15:8];
      end
      merge = n & keep;
   endfunction

   assign idx = avs_address_i[can_filt_pkg::IDX_LSB +: 6];
   assign fi.clk = sys_clk_i;
   assign fi.rst = srst_i;
   assign fi.frame_ext = frame_ext_i;
   assign fi.frame_sid = frame_sid_i;
   assign fi.frame_eid = frame_eid_i;
   assign fi.flt_sid = st.flt_sid;
   assign fi.flt_eid = st.flt_eid;
   assign fi.msk_sid = st.msk_sid;
   assign fi.msk_eid = st.msk_eid;
   assign fi.msk_sel = {st.sel_hi, st.sel_lo};
   assign fi.buf_ptr = st.buf_ptr;

   can_filt_match u_match (
      .m(fi.match)
   );

   // Writes finish at once; reads wait one cycle so read data comes from a flip-flop.
   assign avs_waitrequest_o = avs_read_i && !st.rd_done;
   assign avs_readdata_o = {16'h0000, st.rdata};
   assign accept_valid_o = st.acc_valid;
   assign accept_filter_o = st.acc_filter;
   assign accept_buffer_o = st.acc_ptr;
   assign accept_fifo_o = st.acc_valid && (st.acc_ptr == can_filt_pkg::PTR_FIFO);

   always_comb begin
      logic [5:0] off;
      off = '0;
      next_st = st;
      next_st.rd_done = avs_read_i && !st.rd_done;
      if (avs_write_i) begin
         if (in_range(idx, can_filt_pkg::IDX_FLT_SID, can_filt_pkg::IDX_FLT_EID)) begin
            off = idx - can_filt_pkg::IDX_FLT_SID;
            next_st.flt_sid[off[3:0]] = merge(st.flt_sid[off[3:0]], avs_writedata_i, avs_byteenable_i,
                                              can_filt_pkg::SID_REG_MASK);
         end else if (in_range(idx, can_filt_pkg::IDX_FLT_EID, can_filt_pkg::IDX_MSK_SID)) begin
            off = idx - can_filt_pkg::IDX_FLT_EID;
            next_st.flt_eid[off[3:0]] = merge(st.flt_eid[off[3:0]], avs_writedata_i, avs_byteenable_i,
                                              16'hffff);
         end else if (in_range(idx, can_filt_pkg::IDX_MSK_SID, can_filt_pkg::IDX_MSK_EID)) begin
            off = idx - can_filt_pkg::IDX_MSK_SID;
            next_st.msk_sid[off[1:0]] = merge(st.msk_sid[off[1:0]], avs_writedata_i, avs_byteenable_i,
                                              can_filt_pkg::SID_REG_MASK);
         end else if (in_range(idx, can_filt_pkg::IDX_MSK_EID, can_filt_pkg::IDX_SEL_LO)) begin
            off = idx - can_filt_pkg::IDX_MSK_EID;
            next_st.msk_eid[off[1:0]] = merge(st.msk_eid[off[1:0]], avs_writedata_i, avs_byteenable_i,
                                              16'hffff);
         end else if (idx == can_filt_pkg::IDX_SEL_LO) begin
            next_st.sel_lo = merge(st.sel_lo, avs_writedata_i, avs_byteenable_i, 16'hffff);
         end else if (idx == can_filt_pkg::IDX_SEL_HI) begin
            next_st.sel_hi = merge(st.sel_hi, avs_writedata_i, avs_byteenable_i, 16'hffff);
         end else if (in_range(idx, can_filt_pkg::IDX_BUF_PTR, can_filt_pkg::IDX_END)) begin
            off = idx - can_filt_pkg::IDX_BUF_PTR;
            next_st.buf_ptr[off[1:0]] = merge(st.buf_ptr[off[1:0]], avs_writedata_i, avs_byteenable_i,
                                              16'hffff);
         end
      end
      // Unmapped addresses read as zero and ignore writes.
      next_st.rdata = '0;
      if (in_range(idx, can_filt_pkg::IDX_FLT_SID, can_filt_pkg::IDX_FLT_EID)) begin
         off = idx - can_filt_pkg::IDX_FLT_SID;
         next_st.rdata = st.flt_sid[off[3:0]];
      end else if (in_range(idx, can_filt_pkg::IDX_FLT_EID, can_filt_pkg::IDX_MSK_SID)) begin
         off = idx - can_filt_pkg::IDX_FLT_EID;
         next_st.rdata = st.flt_eid[off[3:0]];
      end else if (in_range(idx, can_filt_pkg::IDX_MSK_SID, can_filt_pkg::IDX_MSK_EID)) begin
         off = idx - can_filt_pkg::IDX_MSK_SID;
         next_st.rdata = st.msk_sid[off[1:0]];
      end else if (in_range(idx, can_filt_pkg::IDX_MSK_EID, can_filt_pkg::IDX_SEL_LO)) begin
         off = idx - can_filt_pkg::IDX_MSK_EID;
         next_st.rdata = st.msk_eid[off[1:0]];
      end else if (idx == can_filt_pkg::IDX_SEL_LO) begin
         next_st.rdata = st.sel_lo;
      end else if (idx == can_filt_pkg::IDX_SEL_HI) begin
         next_st.rdata = st.sel_hi;
      end else if (in_range(idx, can_filt_pkg::IDX_BUF_PTR, can_filt_pkg::IDX_END)) begin
         off = idx - can_filt_pkg::IDX_BUF_PTR;
         next_st.rdata = st.buf_ptr[off[1:0]];
      end
      next_st.acc_valid = frame_valid_i && fi.hit_any;
      if (frame_valid_i && fi.hit_any) begin
         next_st.acc_filter = fi.hit_index;
         next_st.acc_ptr = fi.hit_ptr;
      end
   end

   // Filter and mask contents are undefined to software but are zeroed here for clean simulation.
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         st <= '0;
         st.sel_lo <= can_filt_pkg::SEL_RESET;
         st.sel_hi <= can_filt_pkg::SEL_RESET;
      end else begin
         st <= next_st;
      end
   end

   chk_sel_lo_write: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (avs_write_i && idx == can_filt_pkg::IDX_SEL_LO && avs_byteenable_i[1:0] == 2'h3)
      |=> st.sel_lo == $past(avs_writedata_i[15:0]))
      else $error("low selection register did not take the write");
   chk_sel_hi_write: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (avs_write_i && idx == can_filt_pkg::IDX_SEL_HI && avs_byteenable_i[1:0] == 2'h3)
      |=> fi.msk_sel[31:16] == $past(avs_writedata_i[15:0]))
      else $error("high selection register did not take the write");
   chk_sel_hi_byte: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (avs_write_i && idx == can_filt_pkg::IDX_SEL_HI && avs_byteenable_i[1:0] == 2'h2)
      |=> (st.sel_hi[7:0] == $past(st.sel_hi[7:0]) && st.sel_hi[15:8] == $past(avs_writedata_i[15:8])))
      else $error("high selection register byte write spilled into the other byte");
   chk_sel_reset: assert property (@(posedge sys_clk_i)
      srst_i |=> (st.sel_lo == 16'h0000 && st.sel_hi == 16'h0000))
      else $error("selection registers not cleared by reset");
   chk_read_answer: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (avs_read_i && avs_waitrequest_o) |=> (avs_read_i |-> !avs_waitrequest_o))
      else $error("read not answered in one cycle");
   chk_accept_route: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (frame_valid_i && fi.hit_any) |=> (accept_valid_o && accept_buffer_o == $past(fi.buf_ptr[4*fi.hit_index +: 4])))
      else $error("accepted frame not routed by its filter pointer");
   chk_fifo_flag: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      accept_valid_o |-> (accept_fifo_o == (accept_buffer_o == 4'hf)))
      else $error("fifo flag disagrees with pointer");
   chk_mask_pick: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (frame_valid_i && st.sel_lo[1:0] == 2'h1 && st.msk_sid[1] == 16'h0000 && st.msk_eid[1] == 16'h0000)
      |=> (accept_valid_o && accept_filter_o == 4'h0))
      else $error("filter 0 with an all-clear mask 1 was not accepted first");

   chk_write_no_wait: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (avs_write_i && !avs_read_i) |-> !avs_waitrequest_o)
      else $error("write request was held off");
   // Read data leave a flip-flop a cycle after the address, so the register must still agree then.
   chk_sel_lo_read: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (avs_read_i && !avs_waitrequest_o && idx == can_filt_pkg::IDX_SEL_LO)
      |-> avs_readdata_o == {16'h0000, st.sel_lo})
      else $error("low selection register read back wrong");
   chk_sel_hi_read: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (avs_read_i && !avs_waitrequest_o && idx == can_filt_pkg::IDX_SEL_HI)
      |-> avs_readdata_o == {16'h0000, st.sel_hi})
      else $error("high selection register read back wrong");

   // Filter and buffer outputs hold between acceptances, so downstream logic may read them late.
   chk_no_hit_quiet: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (!frame_valid_i || !fi.hit_any)
      |=> (!accept_valid_o && $stable(accept_filter_o) && $stable(accept_buffer_o)))
      else $error("acceptance outputs moved without an accepted frame");
   chk_fifo_quiet: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      !accept_valid_o |-> !accept_fifo_o)
      else $error("fifo flag raised without an accepted frame");
endmodule // can_filt_top

/* verif/can_node_model.sv */
/*
 Model of the other nodes: hands received identifiers to the filter, one cycle each.
 Assumes the caller steps on the rising edge of clk_i.
*/
`timescale 1ns/1ps
module can_node_model (
   // Clock
   input wire logic clk_i,
   // Received identifier
   output logic frame_valid_o,
   output logic frame_ext_o,
   output logic [10:0] frame_sid_o,
   output logic [17:0] frame_eid_o
);
   initial begin
      frame_valid_o = 1'b0;
      frame_ext_o = 1'b0;
      frame_sid_o = 11'h000;
      frame_eid_o = 18'h00000;
   end
   // Idle lines carry the inverse of the last frame, so stale identifiers cannot pass unseen.
   task automatic send(input logic e, input logic [10:0] s, input logic [17:0] d, input logic more);
      frame_valid_o <= 1'b1;
      frame_ext_o <= e;
      frame_sid_o <= s;
      frame_eid_o <= d;
      @(posedge clk_i);
      if (!more) begin
         frame_valid_o <= 1'b0;
         frame_ext_o <= ~e;
         frame_sid_o <= ~s;
         frame_eid_o <= ~d;
         @(posedge clk_i);
      end
   endtask
endmodule // can_node_model

/* verif/can_acceptance_filter_mask_select_tb_top.sv */
/*
 Self-checking bench: registers over Avalon-MM, frames from the node model.
 Assumes the package and the node model are compiled first.
*/
`timescale 1ns/1ps
module can_acceptance_filter_mask_select_tb_top;
   logic sys_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [7:0] avs_address_i = 8'h00;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0] avs_byteenable_i = 4'hf;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic frame_valid_i;
   logic frame_ext_i;
   logic [10:0] frame_sid_i;
   logic [17:0] frame_eid_i;
   logic accept_valid_o;
   logic [3:0] accept_filter_o;
   logic [3:0] accept_buffer_o;
   logic accept_fifo_o;
   int err_count = 0;
   int n_tests = 0;
   logic [15:0] fsid [16];
   logic [15:0] feid [16];
   logic [15:0] msid [3];
   logic [15:0] meid [3];
   logic [1:0] sel [16];
   logic [3:0] ptr [16];
   logic [9:0] expq [$];
   logic [31:0] rd;

   always #5 sys_clk_i = ~sys_clk_i;

   can_filt_top DUT (.sys_clk_i, .srst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
      .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .frame_valid_i, .frame_ext_i, .frame_sid_i,
      .frame_eid_i, .accept_valid_o, .accept_filter_o, .accept_buffer_o, .accept_fifo_o);
   can_node_model src (.clk_i(sys_clk_i), .frame_valid_o(frame_valid_i), .frame_ext_o(frame_ext_i),
      .frame_sid_o(frame_sid_i), .frame_eid_o(frame_eid_i));

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected register value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_acc(input logic [9:0] got, input logic [9:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected acceptance at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [5:0] idx, input logic [15:0] d, input logic [3:0] be);
      int n;
      n = 0;
      avs_address_i <= {idx, 2'b00};
      avs_read_i <= ~wr;
      avs_write_i <= wr;
      avs_writedata_i <= {16'h0000, d};
      avs_byteenable_i <= be;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 20);
      rd = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      if (avs_waitrequest_o !== 1'b0) begin
         err_count++;
         report_and_stop();
      end
      @(posedge sys_clk_i);
   endtask

   task automatic chk(input logic [5:0] idx, input logic [15:0] exp);
      bus(1'b0, idx, 16'h0000, 4'hf);
      cmp_reg(rd, {16'h0000, exp});
   endtask

   function automatic logic [15:0] selw(input int h);
      logic [15:0] v;
      for (int k = 0; k < 8; k++) begin
         v[2*k +: 2] = sel[8*h+k];
      end
      return v;
   endfunction

   function automatic logic [9:0] ref_acc(input logic e, input logic [10:0] s, input logic [17:0] d);
      logic ok;
      logic [15:0] m;
      for (int k = 0; k < 16; k++) begin
         m = msid[sel[k]];
         ok = ((s ^ fsid[k][15:5]) & m[15:5]) == 11'h000;
         if (e) begin
            ok = ok && (((d ^ {fsid[k][1:0], feid[k]}) & {m[1:0], meid[sel[k]]}) == 18'h0);
         end
         if (m[3]) begin
            ok = ok && (e == fsid[k][3]);
         end
         if (ok) begin
            return {1'b1, 4'(k), ptr[k], ptr[k] == can_filt_pkg::PTR_FIFO};
         end
      end
      return 10'h000;
   endfunction

   // Sparse masks leave most bits as don't-care, so random frames still hit now and then.
   task automatic cfg(input int r);
      for (int k = 0; k < 16; k++) begin
         fsid[k] = 16'($urandom) & can_filt_pkg::SID_REG_MASK;
         feid[k] = 16'($urandom);
         sel[k] = (k == 0) ? 2'(r) : 2'($urandom_range(2));
         ptr[k] = (k == 3) ? can_filt_pkg::PTR_FIFO : 4'($urandom_range(15));
         bus(1'b1, can_filt_pkg::IDX_FLT_SID + 6'(k), fsid[k], 4'hf);
         bus(1'b1, can_filt_pkg::IDX_FLT_EID + 6'(k), feid[k], 4'hf);
      end
      for (int m = 0; m < 3; m++) begin
         msid[m] = 16'($urandom & $urandom) & can_filt_pkg::SID_REG_MASK;
         msid[m][3] = (m != 2);
         meid[m] = 16'($urandom & $urandom);
         bus(1'b1, can_filt_pkg::IDX_MSK_SID + 6'(m), msid[m], 4'hf);
         bus(1'b1, can_filt_pkg::IDX_MSK_EID + 6'(m), meid[m], 4'hf);
      end
      bus(1'b1, can_filt_pkg::IDX_SEL_LO, selw(0), 4'hf);
      bus(1'b1, can_filt_pkg::IDX_SEL_HI, selw(1), 4'hf);
      for (int j = 0; j < 4; j++) begin
         bus(1'b1, can_filt_pkg::IDX_BUF_PTR + 6'(j), {ptr[4*j+3], ptr[4*j+2], ptr[4*j+1], ptr[4*j]}, 4'hf);
      end
   endtask

   task automatic frame(input logic more);
      int k;
      logic e;
      logic [10:0] s;
      logic [17:0] d;
      logic [9:0] ex;
      k = $urandom_range(15);
      e = 1'($urandom);
      s = fsid[k][15:5] ^ (($urandom_range(2) == 0) ? 11'h001 << $urandom_range(10) : 11'h000);
      d = {fsid[k][1:0], feid[k]} ^ (($urandom_range(2) == 0) ? 18'h00001 << $urandom_range(17) : 18'h00000);
      ex = ref_acc(e, s, d);
      if (ex[9]) begin
         expq.push_back(ex);
      end
      src.send(e, s, d, more);
   endtask

   always @(posedge sys_clk_i) begin
      if (srst_i === 1'b0 && accept_valid_o !== 1'b0) begin
         if (expq.size() == 0) begin
            cmp_acc({accept_valid_o, accept_filter_o, accept_buffer_o, accept_fifo_o}, 10'h000);
         end else begin
            cmp_acc({accept_valid_o, accept_filter_o, accept_buffer_o, accept_fifo_o}, expq.pop_front());
         end
      end
   end

   initial begin
      void'($urandom(49));
      repeat (4) @(posedge sys_clk_i);
      srst_i <= 1'b0;
      @(posedge sys_clk_i);
      chk(can_filt_pkg::IDX_SEL_LO, can_filt_pkg::SEL_RESET);
      chk(can_filt_pkg::IDX_SEL_HI, can_filt_pkg::SEL_RESET);
      for (int r = 0; r < 3; r++) begin
         cfg(r);
         chk(can_filt_pkg::IDX_SEL_LO, selw(0));
         chk(can_filt_pkg::IDX_SEL_HI, selw(1));
         chk(can_filt_pkg::IDX_FLT_SID + 6'(r), fsid[r]);
         chk(can_filt_pkg::IDX_FLT_EID + 6'(r + 13), feid[r + 13]);
         for (int i = 0; i < 80; i++) begin
            frame(~i[0]);
         end
      end
      bus(1'b1, can_filt_pkg::IDX_SEL_HI, 16'h9999, 4'h2);
      for (int i = 0; i < 4; i++) begin
         sel[12 + i] = 2'(8'h99 >> (2 * i));
      end
      chk(can_filt_pkg::IDX_SEL_HI, selw(1));
      bus(1'b1, can_filt_pkg::IDX_END, 16'hffff, 4'hf);
      chk(can_filt_pkg::IDX_END, 16'h0000);
      // An all-clear mask 1 on filter 0 makes it take every frame ahead of the others.
      msid[1] = 16'h0000;
      meid[1] = 16'h0000;
      sel[0] = can_filt_pkg::MSK_SET1;
      bus(1'b1, can_filt_pkg::IDX_MSK_SID + 6'h01, msid[1], 4'hf);
      bus(1'b1, can_filt_pkg::IDX_MSK_EID + 6'h01, meid[1], 4'hf);
      bus(1'b1, can_filt_pkg::IDX_SEL_LO, selw(0), 4'hf);
      for (int i = 0; i < 40; i++) begin
         frame(~i[0]);
      end
      repeat (3) @(posedge sys_clk_i);
      cmp_reg(32'(expq.size()), 32'h0);
      report_and_stop();
   end
endmodule // can_acceptance_filter_mask_select_tb_top
